/* edge_sync.sv */
// Two-stage synchroniser followed by a rising-edge detector, per bit.
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] last;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_last;

  // The first stage feeds only the second; edges are judged on settled values.
  always_comb
  begin
    next_meta = async_in;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      stable <= '0;
      last <= '0;
    end
    else
    begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  // A rising edge is a settled high that was low one cycle before.
  assign rise = stable & ~last;

endmodule
`default_nettype wire

/* irq_core_model.sv */
// Behavioural model of the processor core's three interrupt inputs.
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] request,
  output logic [1:0] serving
);
  // The core serves the highest requesting level; 3 means idle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      serving <= 2'h3;
    else if (request[2])
      serving <= 2'h2;
    else if (request[1])
      serving <= 2'h1;
    else if (request[0])
      serving <= 2'h0;
    else
      serving <= 2'h3;
  end
endmodule
`default_nettype wire

/* irq_ctrl_pkg.sv */
// Shared constants and types for the three-level interrupt controller.
package irq_ctrl_pkg;

  // Register indices as printed; the APB byte address is four times the index.
  localparam logic [7:0] IDX_HIGH_FLAGS = 8'h40;
  localparam logic [7:0] IDX_MIDDLE_FLAGS = 8'h41;
  localparam logic [7:0] IDX_LOW_FLAGS = 8'h42;
  localparam logic [7:0] IDX_HIGH_ENABLES = 8'h43;
  localparam logic [7:0] IDX_MIDDLE_ENABLES = 8'h44;
  localparam logic [7:0] IDX_LOW_ENABLES = 8'h45;
  localparam logic [7:0] IDX_PRIORITY = 8'h46;
  localparam logic [7:0] IDX_SUMMARY = 8'h47;
  // Bus-side interrupt status and mask registers.
  localparam logic [7:0] IDX_BUS_STATUS = 8'h48;
  localparam logic [7:0] IDX_BUS_MASK = 8'h49;

  // Reset values.
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'hff;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [2:0] BUS_STATUS_RESET = 3'h0;
  localparam logic [2:0] BUS_MASK_RESET = 3'h0;

  // Valid bits of the high level; its top bit is reserved.
  localparam logic [7:0] HIGH_VALID_MASK = 8'h7f;

  // Summary bit positions, also used for the bus status and mask.
  localparam int SUM_HIGH_BIT = 2;
  localparam int SUM_MIDDLE_BIT = 1;
  localparam int SUM_LOW_BIT = 0;

  // Base of each level in the priority number.
  localparam logic [7:0] HIGH_NUMBER_BASE = 8'h10;
  localparam logic [7:0] MIDDLE_NUMBER_BASE = 8'h08;
  localparam logic [7:0] LOW_NUMBER_BASE = 8'h00;
  localparam logic [7:0] NONE_PENDING = 8'hff;

  // Synchroniser depth before edge detection.
  localparam int SYNC_STAGES = 2;

  // One byte per priority level.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] middle;
    logic [7:0] low;
  } levels_t;

endpackage

/* irq_ctrl_props.sv */
// Port-level checks for the three-level interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tick_128_hertz,
  input wire logic spi_source,
  input wire logic counter_a_source,
  input wire logic counter_c_source,
  input wire logic codec_source,
  input wire logic sequencer_serial_transmit,
  input wire logic sequencer_serial_receive,
  input wire logic high_level_request,
  input wire logic middle_level_request
);
  logic high_any;
  logic rd;
  // A high request may only rise after one of its sources was held high.
  assign high_any = tick_128_hertz | spi_source | counter_a_source | counter_c_source |
    codec_source | sequencer_serial_transmit | sequencer_serial_receive;
  assign rd = pready && !pwrite && !pslverr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  pready_pulse_a:
    assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse");
  high_rise_a:
    assert property ($rose(high_level_request) |-> $past(high_any, 3))
    else $error("high request rose without a source edge");
  high_sticky_a:
    assert property ($fell(high_level_request) |-> pready && pwrite && paddr == 12'h100)
    else $error("high request fell without a clearing write");
  mid_sticky_a:
    assert property ($fell(middle_level_request) |-> pready && pwrite && paddr == 12'h104)
    else $error("middle request fell without a clearing write");
  idle_index_a:
    assert property (rd && paddr == 12'h118 && !high_level_request |-> prdata[7:4] != 4'h1)
    else $error("index claims a high level while none is pending");
  summary_high_a:
    assert property (rd && paddr == 12'h11c |-> prdata[31:1] == {29'h0, high_level_request,
      middle_level_request})
    else $error("summary disagrees with request lines");
  reserved_bit_a:
    assert property (rd && (paddr == 12'h100 || paddr == 12'h10c) |-> prdata[31:7] == 25'h0)
    else $error("reserved high bit read as one");
  bad_addr_a:
    assert property (pready && (paddr < 12'h100 || paddr > 12'h124 || paddr[1:0] != 2'h0)
      |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  cover property ($rose(high_level_request));
  cover property ($fell(middle_level_request));
  cover property (pready && pslverr);
endmodule
bind three_level_irq_controller irq_ctrl_props #(.ADDR_WIDTH(ADDR_WIDTH)) props (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick_128_hertz(tick_128_hertz), .spi_source(spi_source),
  .counter_a_source(counter_a_source), .counter_c_source(counter_c_source),
  .codec_source(codec_source), .sequencer_serial_transmit(sequencer_serial_transmit),
  .sequencer_serial_receive(sequencer_serial_receive),
  .high_level_request(high_level_request), .middle_level_request(middle_level_request));
`default_nettype wire

/* three_level_irq_controller.sv */
// Three-level interrupt controller with an APB register slave.
//
// Overview of operation
// - 23 sources in three levels of eight; high bit 7 unused.
// - High flags: tick, SPI, counters, codec, sequencer serial.
// - Middle flags: application serial, ports, tick, wake-up.
// - Low flags: ports, counters, both flow controls.
// - Flags reset to zero; write one clears.
// - Per-level enables; reset zero; high bit 7 zero.
// - Read-only index of highest pending, resets ones.
// - Read-only summary: bit per level pending.
// - Exactly three levels, each own register group.
// - Flag sets on enabled rising edge; sticky.
// - Writing zero leaves a flag unchanged.
// - Index reads all ones when nothing pending.
// - Sources synchronised to fastest clock before edges.
`timescale 1ns/1ps
`default_nettype none
module three_level_irq_controller #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // High-level sources.
  input wire logic tick_128_hertz,
  input wire logic spi_source,
  input wire logic counter_a_source,
  input wire logic counter_c_source,
  input wire logic codec_source,
  input wire logic sequencer_serial_transmit,
  input wire logic sequencer_serial_receive,
  // Middle-level sources.
  input wire logic application_serial_transmit,
  input wire logic application_serial_receive,
  input wire logic port_line_5_source,
  input wire logic port_line_4_source,
  input wire logic tick_1_hertz,
  input wire logic wakeup_source,
  input wire logic port_line_1_source,
  input wire logic port_line_0_source,
  // Low-level sources.
  input wire logic port_line_7_source,
  input wire logic port_line_6_source,
  input wire logic counter_b_source,
  input wire logic counter_d_source,
  input wire logic port_line_3_source,
  input wire logic port_line_2_source,
  input wire logic sequencer_serial_flow_control,
  input wire logic application_serial_flow_control,
  // Requests to the processor core, one per level.
  output logic high_level_request,
  output logic middle_level_request,
  output logic low_level_request,
  // Bus-side interrupt.
  output logic irq
);

  irq_ctrl_pkg::levels_t raw_sources;
  irq_ctrl_pkg::levels_t source_rise;
  irq_ctrl_pkg::levels_t flags;
  irq_ctrl_pkg::levels_t next_flags;
  irq_ctrl_pkg::levels_t enables;
  irq_ctrl_pkg::levels_t next_enables;
  irq_ctrl_pkg::levels_t clear_mask;
  logic [7:0] highest_pending_index;
  logic [7:0] next_highest_pending_index;
  logic [7:0] pending_level_summary;
  logic [7:0] next_pending_level_summary;
  logic [2:0] bus_status;
  logic [2:0] next_bus_status;
  logic [2:0] bus_mask;
  logic [2:0] next_bus_mask;
  logic [2:0] level_new_flag;
  logic [2:0] next_requests;
  logic next_irq;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;
  logic wr_strobe;
  logic rd_strobe;
  logic hit;
  logic [31:0] read_word;
  logic [7:0] word_index;
  logic addr_aligned;

  // Place each source at its documented bit; the high level has no bit 7.
  assign raw_sources.high = {1'b0, tick_128_hertz, spi_source, counter_a_source,
    counter_c_source, codec_source, sequencer_serial_transmit,
    sequencer_serial_receive};
  assign raw_sources.middle = {application_serial_transmit, application_serial_receive,
    port_line_5_source, port_line_4_source, tick_1_hertz, wakeup_source,
    port_line_1_source, port_line_0_source};
  assign raw_sources.low = {port_line_7_source, port_line_6_source, counter_b_source,
    counter_d_source, port_line_3_source, port_line_2_source,
    sequencer_serial_flow_control, application_serial_flow_control};

  // Every source is clocked twice on the system clock before its edge is judged.
  edge_sync #(
    .WIDTH(24)
  ) u_edge_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(raw_sources),
    .rise(source_rise)
  );

  // APB decode. A transfer completes on the second access cycle, when pready rises.
  assign access = psel && penable && !pready;
  assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_WIDTH-1:10] == '0);
  assign word_index = paddr[9:2];
  assign wr_strobe = access && pwrite && hit && pstrb[0];
  assign rd_strobe = access && !pwrite && hit;

  // Address decode and read data; any other word answers with an error.
  always_comb
  begin
    hit = addr_aligned;
    read_word = 32'h0000_0000;
    if (word_index == irq_ctrl_pkg::IDX_HIGH_FLAGS)
    begin
      read_word[7:0] = flags.high & irq_ctrl_pkg::HIGH_VALID_MASK;
    end
    else if (word_index == irq_ctrl_pkg::IDX_MIDDLE_FLAGS)
    begin
      read_word[7:0] = flags.middle;
    end
    else if (word_index == irq_ctrl_pkg::IDX_LOW_FLAGS)
    begin
      read_word[7:0] = flags.low;
    end
    else if (word_index == irq_ctrl_pkg::IDX_HIGH_ENABLES)
    begin
      read_word[7:0] = enables.high & irq_ctrl_pkg::HIGH_VALID_MASK;
    end
    else if (word_index == irq_ctrl_pkg::IDX_MIDDLE_ENABLES)
    begin
      read_word[7:0] = enables.middle;
    end
    else if (word_index == irq_ctrl_pkg::IDX_LOW_ENABLES)
    begin
      read_word[7:0] = enables.low;
    end
    else if (word_index == irq_ctrl_pkg::IDX_PRIORITY)
    begin
      read_word[7:0] = highest_pending_index;
    end
    else if (word_index == irq_ctrl_pkg::IDX_SUMMARY)
    begin
      read_word[7:0] = pending_level_summary;
    end
    else if (word_index == irq_ctrl_pkg::IDX_BUS_STATUS)
    begin
      read_word[2:0] = bus_status;
    end
    else if (word_index == irq_ctrl_pkg::IDX_BUS_MASK)
    begin
      read_word[2:0] = bus_mask;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // Bus answer, registered so that pready, prdata and pslverr come from flops.
  always_comb
  begin
    next_pready = access;
    next_pslverr = access && !hit;
    next_prdata = prdata;
    if (access && !pwrite)
    begin
      next_prdata = hit ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Write-one-to-clear masks per level; a zero bit leaves its flag alone.
  always_comb
  begin
    clear_mask = '0;
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_HIGH_FLAGS)
    begin
      clear_mask.high = pwdata[7:0];
    end
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_MIDDLE_FLAGS)
    begin
      clear_mask.middle = pwdata[7:0];
    end
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_LOW_FLAGS)
    begin
      clear_mask.low = pwdata[7:0];
    end
  end

  // Flags catch enabled rising edges and hold. A new edge in the clearing
  // cycle wins, so an event is never lost to a late clear.
  always_comb
  begin
    next_flags = (flags & ~clear_mask) | (source_rise & enables);
    next_flags.high = next_flags.high & irq_ctrl_pkg::HIGH_VALID_MASK;
    level_new_flag[irq_ctrl_pkg::SUM_HIGH_BIT] = |(source_rise.high & enables.high
      & irq_ctrl_pkg::HIGH_VALID_MASK);
    level_new_flag[irq_ctrl_pkg::SUM_MIDDLE_BIT] = |(source_rise.middle & enables.middle);
    level_new_flag[irq_ctrl_pkg::SUM_LOW_BIT] = |(source_rise.low & enables.low);
  end

  // Enable registers, one per level, plus the bus-side interrupt mask.
  always_comb
  begin
    next_enables = enables;
    next_bus_mask = bus_mask;
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_HIGH_ENABLES)
    begin
      next_enables.high = pwdata[7:0] & irq_ctrl_pkg::HIGH_VALID_MASK;
    end
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_MIDDLE_ENABLES)
    begin
      next_enables.middle = pwdata[7:0];
    end
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_LOW_ENABLES)
    begin
      next_enables.low = pwdata[7:0];
    end
    if (wr_strobe && word_index == irq_ctrl_pkg::IDX_BUS_MASK)
    begin
      next_bus_mask = pwdata[2:0];
    end
  end

  // Flag and enable storage; all of it clears on reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags.high <= irq_ctrl_pkg::FLAGS_RESET;
      flags.middle <= irq_ctrl_pkg::FLAGS_RESET;
      flags.low <= irq_ctrl_pkg::FLAGS_RESET;
      enables.high <= irq_ctrl_pkg::ENABLES_RESET;
      enables.middle <= irq_ctrl_pkg::ENABLES_RESET;
      enables.low <= irq_ctrl_pkg::ENABLES_RESET;
      bus_mask <= irq_ctrl_pkg::BUS_MASK_RESET;
    end
    else
    begin
      flags <= next_flags;
      enables <= next_enables;
      bus_mask <= next_bus_mask;
    end
  end

  // Highest pending number: high level above middle above low, and within a
  // level the higher bit wins. Computed from the flags as they will stand.
  always_comb
  begin
    next_highest_pending_index = irq_ctrl_pkg::NONE_PENDING;
    for (int i = 0; i < 8; i++)
    begin
      if (next_flags.low[i])
      begin
        next_highest_pending_index = irq_ctrl_pkg::LOW_NUMBER_BASE + 8'(i);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      if (next_flags.middle[i])
      begin
        next_highest_pending_index = irq_ctrl_pkg::MIDDLE_NUMBER_BASE + 8'(i);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      if (next_flags.high[i])
      begin
        next_highest_pending_index = irq_ctrl_pkg::HIGH_NUMBER_BASE + 8'(i);
      end
    end
  end

  // Per-level summary and the core request lines follow the same flags.
  always_comb
  begin
    next_pending_level_summary = irq_ctrl_pkg::SUMMARY_RESET;
    next_pending_level_summary[irq_ctrl_pkg::SUM_HIGH_BIT] = |next_flags.high;
    next_pending_level_summary[irq_ctrl_pkg::SUM_MIDDLE_BIT] = |next_flags.middle;
    next_pending_level_summary[irq_ctrl_pkg::SUM_LOW_BIT] = |next_flags.low;
    next_requests = next_pending_level_summary[2:0];
  end

  // Bus status: a level that gains a flag sets its sticky bit; a read of the
  // status word clears it, but a new event in that same cycle survives.
  always_comb
  begin
    next_bus_status = bus_status;
    if (rd_strobe && word_index == irq_ctrl_pkg::IDX_BUS_STATUS)
    begin
      next_bus_status = 3'h0;
    end
    next_bus_status = next_bus_status | level_new_flag;
    next_irq = |(next_bus_status & bus_mask);
  end

  // Derived state and outputs, all held in flops.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      highest_pending_index <= irq_ctrl_pkg::PRIORITY_RESET;
      pending_level_summary <= irq_ctrl_pkg::SUMMARY_RESET;
      bus_status <= irq_ctrl_pkg::BUS_STATUS_RESET;
      high_level_request <= 1'b0;
      middle_level_request <= 1'b0;
      low_level_request <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      highest_pending_index <= next_highest_pending_index;
      pending_level_summary <= next_pending_level_summary;
      bus_status <= next_bus_status;
      high_level_request <= next_requests[irq_ctrl_pkg::SUM_HIGH_BIT];
      middle_level_request <= next_requests[irq_ctrl_pkg::SUM_MIDDLE_BIT];
      low_level_request <= next_requests[irq_ctrl_pkg::SUM_LOW_BIT];
      irq <= next_irq;
    end
  end

endmodule
`default_nettype wire

/* three_level_irq_controller_tb.sv */
// Self-checking testbench for the three-level interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module three_level_irq_controller_tb;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [23:0] src;
  logic [2:0] req;
  logic [1:0] serving;
  logic e;
  int error_cnt, samples_checked;

  // Sources: bits 22..16 high level (23 unused), 15..8 middle, 7..0 low.
  three_level_irq_controller DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_128_hertz(src[22]),
    .spi_source(src[21]), .counter_a_source(src[20]), .counter_c_source(src[19]),
    .codec_source(src[18]), .sequencer_serial_transmit(src[17]),
    .sequencer_serial_receive(src[16]), .application_serial_transmit(src[15]),
    .application_serial_receive(src[14]), .port_line_5_source(src[13]),
    .port_line_4_source(src[12]), .tick_1_hertz(src[11]), .wakeup_source(src[10]),
    .port_line_1_source(src[9]), .port_line_0_source(src[8]), .port_line_7_source(src[7]),
    .port_line_6_source(src[6]), .counter_b_source(src[5]), .counter_d_source(src[4]),
    .port_line_3_source(src[3]), .port_line_2_source(src[2]),
    .sequencer_serial_flow_control(src[1]), .application_serial_flow_control(src[0]),
    .high_level_request(req[2]), .middle_level_request(req[1]),
    .low_level_request(req[0]), .irq(irq));
  irq_core_model core (.clk(clk), .arst_n(arst_n), .request(req), .serving(serving));

  always #5 clk = ~clk;

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
      error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // A level is held three cycles so the synchroniser sees a clean edge.
  task automatic pulse(input int i);
    src[i] <= 1'b1;
    repeat (3) @(posedge clk);
    src[i] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, src} = '0;
    pstrb = 4'hf;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int j = 0; j < 10; j++)
      rd(ad(8'(irq_ctrl_pkg::IDX_HIGH_FLAGS + j)), (j == 6) ? 32'hff : 32'h0);
    apb(1'b0, 12'h128, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h101, 32'hff);
    chk({31'h0, e}, 32'h1);
    $display("reset and map test done");
    for (int i = 0; i < 24; i++)
      pulse(i);
    for (int l = 0; l < 3; l++)
      rd(ad(8'(irq_ctrl_pkg::IDX_LOW_FLAGS - l)), 32'h0);
    for (int l = 0; l < 3; l++)
    begin
      apb(1'b1, ad(8'(irq_ctrl_pkg::IDX_LOW_ENABLES - l)), 32'hff);
      rd(ad(8'(irq_ctrl_pkg::IDX_LOW_ENABLES - l)), (l == 2) ? 32'h7f : 32'hff);
    end
    $display("disabled edge test done");
    for (int i = 0; i < 23; i++)
    begin
      pulse(i);
      rd(ad(8'(irq_ctrl_pkg::IDX_LOW_FLAGS - i / 8)), 32'h1 << (i % 8));
      rd(ad(irq_ctrl_pkg::IDX_PRIORITY), 32'(i));
      rd(ad(irq_ctrl_pkg::IDX_SUMMARY), 32'h1 << (i / 8));
      apb(1'b1, ad(8'(irq_ctrl_pkg::IDX_LOW_FLAGS - i / 8)), 32'h1 << (i % 8));
      rd(ad(8'(irq_ctrl_pkg::IDX_LOW_FLAGS - i / 8)), 32'h0);
    end
    $display("per source test done");
    pulse(3);
    pulse(10);
    // The source passes two sync stages and the request flop, so the test first sees the request at edge 4.
    src[16] <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, req[2]}, 32'h0);
    @(posedge clk);
    chk({31'h0, req[2]}, 32'h1);
    src[16] <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ad(irq_ctrl_pkg::IDX_PRIORITY), 32'h10);
    chk({30'h0, serving}, 32'h2);
    apb(1'b1, ad(irq_ctrl_pkg::IDX_HIGH_FLAGS), 32'h0);
    rd(ad(irq_ctrl_pkg::IDX_HIGH_FLAGS), 32'h1);
    apb(1'b1, ad(irq_ctrl_pkg::IDX_HIGH_FLAGS), 32'h1);
    rd(ad(irq_ctrl_pkg::IDX_PRIORITY), 32'h0a);
    rd(ad(irq_ctrl_pkg::IDX_SUMMARY), 32'h3);
    chk({30'h0, serving}, 32'h1);
    apb(1'b1, ad(irq_ctrl_pkg::IDX_MIDDLE_FLAGS), 32'h4);
    rd(ad(irq_ctrl_pkg::IDX_PRIORITY), 32'h3);
    chk({30'h0, serving}, 32'h0);
    apb(1'b1, ad(irq_ctrl_pkg::IDX_LOW_FLAGS), 32'h8);
    rd(ad(irq_ctrl_pkg::IDX_PRIORITY), 32'hff);
    rd(ad(irq_ctrl_pkg::IDX_SUMMARY), 32'h0);
    $display("priority test done");
    rd(ad(irq_ctrl_pkg::IDX_BUS_STATUS), 32'h7);
    pulse(5);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ad(irq_ctrl_pkg::IDX_BUS_MASK), 32'h7);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(ad(irq_ctrl_pkg::IDX_BUS_STATUS), 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("bus interrupt test done");
    conclude();
  end
endmodule
`default_nettype wire
